/* hw/kwi_defines.svh */
// Register offsets, field positions, reset values and counts of the key unit
`ifndef KWI_DEFINES_SVH
`define KWI_DEFINES_SVH
`define KWI_ADR_CTRL 4'h0
`define KWI_ADR_PEN 4'h4
`define KWI_ADR_POL 4'h8
`define KWI_ADR_ISTAT 4'hC
`define KWI_BIT_MODE 0
`define KWI_BIT_IE 1
`define KWI_BIT_ACK 2
`define KWI_BIT_FLAG 3
`define KWI_RST_BYTE 8'h00
`define KWI_NPINS 8
`define KWI_PHYS_PINS 7
`endif

/* hw/kwi_detect.sv */
// Per-pin assertion and edge detection of the key unit
`timescale 1ns/1ns
module kwi_detect #(
  parameter int W = 8
) (
  input wire logic clk, // bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] pins, // synchronised pins
  input wire logic [W-1:0] pin_en, // per-pin enable
  input wire logic [W-1:0] pol, // per-pin polarity
  output logic edge_hit, // valid edge this cycle
  output logic any_asserted // some enabled pin asserted
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic armed;
  } kwi_det_st_t;
  kwi_det_st_t st_q, st_d;
  logic [W-1:0] asrt;
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_pin
      // Polarity 0 asserts on low, 1 on high
      assign asrt[g] = pin_en[g] & (pins[g] ~^ pol[g]);
    end
  endgenerate
  always_comb
  begin
    st_d.prev = asrt;
    st_d.armed = st_q.armed;
    // Re-armed only once every enabled pin is released
    if (asrt == '0)
      st_d.armed = 1'b1;
    else if (edge_hit)
      st_d.armed = 1'b0;
  end
  assign edge_hit = st_q.armed && |(asrt & ~st_q.prev);
  assign any_asserted = |asrt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule : kwi_detect

/* hw/kwi_pkg.sv */
// Types shared by the key unit modules
package kwi_pkg;
  typedef struct packed {
    logic detect_mode;
    logic irq_enable;
    logic [7:0] pin_enable;
    logic [7:0] polarity;
  } kwi_cfg_t;
  typedef enum logic [2:0] {
    KWI_RUN = 3'h1,
    KWI_LIGHT_STOP = 3'h2,
    KWI_DEEP_STOP = 3'h4
  } kwi_pmode_t;
endpackage : kwi_pkg

/* hw/kwi_sync.sv */
// Two-stage synchroniser for the key pins
`timescale 1ns/1ns
module kwi_sync #(
  parameter int W = 8
) (
  input wire logic clk, // bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // raw pins
  output logic [W-1:0] q // synchronised pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } kwi_sync_st_t;
  kwi_sync_st_t st_q, st_d;
  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign q = st_q.s2;
endmodule : kwi_sync

/* hw/kwi_top.sv */
// Key interrupt unit with classic Wishbone register slave
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns
`include "kwi_defines.svh"
module kwi_top #(
  parameter int NPINS = `KWI_NPINS,
  parameter int PHYS = `KWI_PHYS_PINS
) (
  input wire logic ref_clk, // bus clock, 50 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [PHYS-1:0] key_input_pin, // key pins
  input wire logic light_stop_mode, // light stop active
  input wire logic deep_stop_mode, // deeper stop active
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic key_irq, // interrupt request, level
  output logic key_wake // wake request to power control
);
  typedef struct packed {
    kwi_pkg::kwi_cfg_t cfg;
    logic flag;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] pend_f;
    logic [1:0] cfg_done;
  } kwi_st_t;

  ////////////////////////////////////////////////////////////////////////////
  kwi_st_t st_q, st_d;
  logic [1:0] rs_q;
  logic rs_clr_n;
  logic rst_sync_n;
  logic core_rst_n;
  logic [3:0] hit;
  logic [NPINS-1:0] pins_raw, pins_s;
  logic edge_hit, any_asserted;
  logic req, wr, rd;
  logic [7:0] ctrl_rd, wbyte;
  logic async_hit;
  logic [PHYS-1:0] async_asrt;

  // One-hot select of the mapped registers, for reads and writes alike
  function automatic logic [3:0] reg_hit(input logic [3:0] adr);
    logic [3:0] sel;
    sel = 4'h0;
    if (adr == `KWI_ADR_CTRL)
      sel = 4'h1;
    else if (adr == `KWI_ADR_PEN)
      sel = 4'h2;
    else if (adr == `KWI_ADR_POL)
      sel = 4'h4;
    else if (adr == `KWI_ADR_ISTAT)
      sel = 4'h8;
    return sel;
  endfunction : reg_hit

  // Unused slot sits at its deasserted level for either polarity
  assign pins_raw = {~st_q.cfg.polarity[NPINS-1:PHYS],
    key_input_pin};

  // Deeper stop clears at once; either release passes two flops
  assign rs_clr_n = rst_n & ~deep_stop_mode;
  always_ff @(posedge ref_clk or negedge rs_clr_n)
  begin
    if (!rs_clr_n)
      rs_q <= 2'h0;
    else
      rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_sync_n = rs_q[1];
  assign core_rst_n = rst_sync_n;

  kwi_sync #(.W(NPINS)) u_sync (
    .clk(ref_clk),
    .rst_n(core_rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  kwi_detect #(.W(NPINS)) u_det (
    .clk(ref_clk),
    .rst_n(core_rst_n),
    .pins(pins_s),
    .pin_en(st_q.cfg.pin_enable),
    .pol(st_q.cfg.polarity),
    .edge_hit(edge_hit),
    .any_asserted(any_asserted)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Light stop: raw combinational look at the pins, no clock needed
  assign async_asrt = key_input_pin
    ~^ st_q.cfg.polarity[PHYS-1:0];
  assign async_hit = light_stop_mode && st_q.cfg_done[0]
    && |(async_asrt & st_q.cfg.pin_enable[PHYS-1:0]);

  assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wbyte = wb_dat_i[7:0];
  assign hit = reg_hit(wb_adr_i);
  // Ack bit always reads 0; bits 7:4 unused
  assign ctrl_rd = {4'h0, st_q.flag, 1'b0, st_q.cfg.irq_enable,
    st_q.cfg.detect_mode};

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    st_d.ack = req;
    st_d.rdata = 32'h0000_0000;
    // Wait and debug halt do not touch the detector: it runs on
    if (rd)
    begin
      if (hit[0])
        st_d.rdata = {24'h00_0000, ctrl_rd};
      else if (hit[1])
        st_d.rdata = {24'h00_0000, st_q.cfg.pin_enable};
      else if (hit[2])
        st_d.rdata = {24'h00_0000, st_q.cfg.polarity};
      else if (hit[3])
        st_d.rdata = {30'h0000_0000, st_q.pend_f};
      else
        st_d.rdata = 32'h0000_0000;
    end
    if (wr && hit[0])
    begin
      st_d.cfg.detect_mode = wbyte[`KWI_BIT_MODE];
      st_d.cfg.irq_enable = wbyte[`KWI_BIT_IE];
      // Level mode keeps flag while any enabled pin asserted
      if (wbyte[`KWI_BIT_ACK]
          && !(st_q.cfg.detect_mode && any_asserted))
        st_d.flag = 1'b0;
    end
    else if (wr && hit[1])
      st_d.cfg.pin_enable = wbyte;
    else if (wr && hit[2])
      st_d.cfg.polarity = wbyte;
    else if (wr && hit[3])
      st_d.pend_f = st_q.pend_f & ~wbyte[1:0];
    // Set wins over clear
    if (edge_hit || (st_q.cfg.detect_mode && any_asserted))
      st_d.flag = 1'b1;
    if (edge_hit)
      st_d.pend_f[0] = 1'b1;
    if (async_hit)
      st_d.pend_f[1] = 1'b1;
    // Configured before stop entry: latched while running
    st_d.cfg_done = {1'b0, |st_q.cfg.pin_enable};
  end

  always_ff @(posedge ref_clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      st_q.cfg <= '0;
      st_q.flag <= 1'b0;
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h0000_0000;
      st_q.pend_f <= 2'h0;
      st_q.cfg_done <= 2'h0;
    end
    else
    begin
      st_q.cfg <= st_d.cfg;
      st_q.flag <= st_d.flag;
      st_q.ack <= st_d.ack;
      st_q.rdata <= st_d.rdata;
      st_q.pend_f <= st_d.pend_f;
      if (!light_stop_mode)
        st_q.cfg_done <= st_d.cfg_done;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdata;
  assign key_irq = st_q.flag & st_q.cfg.irq_enable;
  // Wake in wait or light stop while enabled
  assign key_wake = st_q.cfg.irq_enable
    & (st_q.flag | async_hit);
endmodule : kwi_top

/* test/keypad_wake_interrupt_tb.sv */
// Self-checking bench of the key interrupt unit
`timescale 1ns/1ns
module keypad_wake_interrupt_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic lstop = 1'b0;
  logic dstop = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdo;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic wake;
  logic [6:0] press = 7'h00;
  logic [6:0] pull = 7'h7F;
  logic [6:0] pin;
  int n_fail = 0;
  int checks = 0;
  kwi_keys i_kwi_keys (.press(press), .pull(pull), .pin(pin));
  kwi_top i_kwi_top (.ref_clk(ref_clk), .rst_n(rst_n), .key_input_pin(pin),
    .light_stop_mode(lstop), .deep_stop_mode(dstop), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .key_irq(irq),
    .key_wake(wake));
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // Sampled before this edge's updates land; a hang ends at the watchdog
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic idle;
    repeat (8) @(posedge ref_clk);
  endtask : idle
  task automatic regs_zero;
    for (int a = 0; a < 16; a += 4)
    begin
      wb(1'b0, 4'(a), 32'h0);
      chk(rdat, 32'h0);
    end
    wb(1'b0, 4'h2, 32'h0);
    chk(rdat, 32'h0);
  endtask : regs_zero
  ////////////////////////////////////////////////////////////////////////
  task automatic t_edge;
    wb(1'b1, 4'h8, 32'h0);
    wb(1'b1, 4'h4, 32'h3);
    wb(1'b1, 4'h0, 32'h6);
    press <= 7'h01;
    idle();
    chk(32'(irq), 32'h1);
    wb(1'b0, 4'h0, 32'h0);
    chk(rdat, 32'hA);
    wb(1'b0, 4'hC, 32'h0);
    chk(rdat, 32'h1);
    wb(1'b1, 4'hC, 32'h1);
    wb(1'b0, 4'hC, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, 4'h0, 32'h6);
    press <= 7'h03;
    idle();
    chk(32'(irq), 32'h0);
    press <= 7'h00;
    idle();
    press <= 7'h02;
    idle();
    chk(32'(irq), 32'h1);
    press <= 7'h00;
    wb(1'b1, 4'h0, 32'h4);
    idle();
    press <= 7'h01;
    idle();
    chk(32'(irq), 32'h0);
    wb(1'b1, 4'h0, 32'h2);
    idle();
    chk(32'(irq), 32'h1);
    press <= 7'h00;
    $display("t_edge done");
  endtask : t_edge
  task automatic t_level;
    pull <= 7'h7D;
    wb(1'b1, 4'h8, 32'h2);
    wb(1'b1, 4'h0, 32'h7);
    press <= 7'h02;
    idle();
    wb(1'b1, 4'h0, 32'h7);
    idle();
    chk(32'(irq), 32'h1);
    press <= 7'h00;
    idle();
    wb(1'b1, 4'h0, 32'h7);
    idle();
    chk(32'(irq), 32'h0);
    $display("t_level done");
  endtask : t_level
  task automatic t_stop;
    lstop <= 1'b1;
    idle();
    chk(32'(wake), 32'h0);
    press <= 7'h02;
    // One edge on: only the unclocked path can have seen the key yet
    @(posedge ref_clk);
    chk(32'(wake), 32'h1);
    chk(32'(irq), 32'h0);
    idle();
    wb(1'b0, 4'hC, 32'h0);
    chk(32'(rdat[1]), 32'h1);
    chk(32'(wake), 32'h1);
    dstop <= 1'b1;
    idle();
    chk(32'(wake), 32'h0);
    lstop <= 1'b0;
    dstop <= 1'b0;
    idle();
    regs_zero();
    $display("t_stop done");
  endtask : t_stop
  task automatic test_done;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    #60000;
    n_fail++;
    test_done();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    regs_zero();
    t_edge();
    t_level();
    t_stop();
    test_done();
  end
endmodule : keypad_wake_interrupt_tb

/* test/kwi_checker.sv */
// Port assertions of the key unit
`timescale 1ns/1ns
module kwi_checker (
  input wire logic ref_clk, // clk
  input wire logic rst_n, // rst
  input wire logic light_stop_mode, // lstop
  input wire logic deep_stop_mode, // dstop
  input wire logic wb_cyc_i, // cyc
  input wire logic wb_stb_i, // stb
  input wire logic wb_we_i, // we
  input wire logic [3:0] wb_adr_i, // adr
  input wire logic [31:0] wb_dat_o, // rdata
  input wire logic wb_ack_o, // ack
  input wire logic key_irq, // irq
  input wire logic key_wake // wake
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || deep_stop_mode);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_wr; wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o; endsequence
  property p_resp; s_req |=> wb_ack_o; endproperty
  a_resp: assert property (p_resp) else $error("no ack");
  // A taken write is acked with idle read data
  property p_wdat; s_wr |=> wb_ack_o && wb_dat_o == 32'h0; endproperty
  a_wdat: assert property (p_wdat) else $error("write ack");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data idle");
  property p_ackrd;
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[7:4] == 4'h0 &&
      !wb_dat_o[2];
  endproperty
  a_ackrd: assert property (p_ackrd) else $error("ctrl read");
  property p_run; !light_stop_mode |-> key_wake == key_irq; endproperty
  a_run: assert property (p_run) else $error("wake run");
  property p_iw; key_irq |-> key_wake; endproperty
  a_iw: assert property (p_iw) else $error("wake irq");
  // Only software clears the request
  property p_fall; $fell(key_irq) |-> $past(wb_we_i) && $past(wb_stb_i);
  endproperty
  a_fall: assert property (p_fall) else $error("irq fell");
  property p_deep;
    disable iff (!rst_n) deep_stop_mode |-> !key_irq && !key_wake;
  endproperty
  a_deep: assert property (p_deep) else $error("deep active");
endmodule : kwi_checker
bind kwi_top kwi_checker i_kwi_checker (.ref_clk, .rst_n, .light_stop_mode,
  .deep_stop_mode, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .key_irq, .key_wake);

/* test/kwi_keys.sv */
// Key switch model: switches against pull resistors
`timescale 1ns/1ns
module kwi_keys (
  input wire logic [6:0] press, // closed
  input wire logic [6:0] pull, // 1 up
  output logic [6:0] pin // level
);
  assign pin = press ^ pull;
endmodule : kwi_keys
